// ### mfunc_consts.vh
// Purpose: constants for the multifunction terminal router
// Assumes: byte addresses on the register port, 32-bit data
// Notes:   definitions only
`ifndef MFUNC_CONSTS_VH
`define MFUNC_CONSTS_VH

// register byte offsets
`define OFS_ROUTING        8'h8C
`define OFS_ROUTER_CTRL    8'h94
`define OFS_GP_OUTPUT      8'h98
`define OFS_ROUTER_STATUS  8'h9C

// reset values
`define ROUTING_RESET      32'h00000000
`define ROUTER_CTRL_RESET  2'h0
`define GP_OUTPUT_RESET    5'h00

// writable bits of the routing register; bits 31..28 read zero
`define ROUTING_WR_MASK    32'h0FFFFFFF
// general outputs exist for terminals 0, 1, 2 and 5 (bit 4 drives terminal 5)
`define GP_OUTPUT_MASK     5'h17

// control register bit positions
`define CTRL_RING_EN_BIT   0
`define CTRL_DMA_EN_BIT    1

// status register bit positions
`define STAT_LEVELS_LSB    0
`define STAT_SERIAL_BIT    8
`define STAT_DMA_BIT       9

// select field width and number of terminals
`define SEL_W              4
`define TERM_N             7

// select codes with a meaning outside the terminal tables
`define CODE_DMA_FUNC      4'h2

// per-terminal drive masks, bit n set when code n drives the pin
`define T6_DRIVE_MASK      16'hFFFE
`define T5_DRIVE_MASK      16'hFFDA
`define T3_DRIVE_MASK      16'hFFFE
`define T1_DRIVE_MASK      16'hFEFA
`define T0_DRIVE_MASK      16'hFFFE

`endif

// ### terminal_cell.v
// Purpose: one multifunction terminal output stage
// Assumes: code table prepared by the router, same clock
// Notes:   pin value and enable are both registered
`timescale 1ns/1ps
module terminal_cell (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [3:0]  code,
  input  wire [15:0] src_val,
  input  wire [15:0] src_en,
  input  wire        force_sel,
  input  wire        force_val,
  input  wire        force_oe,
  output reg         pin_out,
  output reg         pin_oe
);

  reg pin_out_nxt;
  reg pin_oe_nxt;

  always @*
  begin
    pin_out_nxt = src_val[code];
    pin_oe_nxt  = src_en[code];
    // serial-bus strapping takes the pin regardless of the field
    if (force_sel)
    begin
      pin_out_nxt = force_val;
      pin_oe_nxt  = force_oe;
    end
    // an undriven pin shows a quiet output level
    if (!pin_oe_nxt)
      pin_out_nxt = 1'b0;
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end
    else
    begin
      pin_out <= pin_out_nxt;
      pin_oe  <= pin_oe_nxt;
    end
  end

endmodule

// ### mfunc_router.v
// Purpose: routing register and pin mux for seven multifunction terminals
// Assumes: one clock; terminal pins and straps come from outside
// Notes:   a preload from the configuration loader wins over a bus write
`timescale 1ns/1ps
`include "mfunc_consts.vh"

// Behaviour
// R01: after reset all terminals are inputs; routing register is zero.
// R02: routing register can be preloaded from the serial configuration loader.
// R03: software should program routing once at start; not enforced.
// R04: bits 31 to 28 read zero and ignore writes.
// R05: terminal 6: reserved, clock-run, or IRQ2 to IRQ15.
// R06: terminal 5 codes per its table, including DMA grant input.
// R07: terminal 4 legible codes only; illegible codes leave pin undriven.
// R08: serial-bus strapping puts the serial clock on terminal 4.
// R09: terminal 3: reserved, serialized interrupt, or IRQ2 to IRQ15.
// R10: terminal 2 codes per its table, including DMA request.
// R11: terminal 1 codes per its table.
// R12: serial-bus strapping puts the serial data line on terminal 1.
// R13: terminal 0 codes per its table, including PCI INTA.
// R14: ring output reaches terminals 2 or 4 only when enabled.
// R15: central DMA works only when enabled and both terminals selected.
// R16: a reserved code leaves its terminal undriven, as an input.
module mfunc_router (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        preload_valid,
  input  wire [31:0] preload_data,
  input  wire [15:0] irq_lines,
  input  wire        clkrun_out,
  input  wire        clkrun_oe,
  input  wire        serialized_interrupt,
  input  wire        serialized_interrupt_oe,
  input  wire        pci_inta,
  input  wire        dma_request_out,
  input  wire        video_port_status,
  input  wire        video_port_select_0,
  input  wire        card_audio_pwm,
  input  wire        socket_activity_led,
  input  wire        general_purpose_event,
  input  wire        ring_indicate_output,
  input  wire        serial_clk_out,
  input  wire        serial_clk_oe,
  input  wire        serial_data_drive_low,
  input  wire        power_strap_a,
  input  wire        power_strap_b,
  input  wire [6:0]  term_in,
  output wire [6:0]  term_out,
  output wire [6:0]  term_oe,
  output reg         dma_grant_in,
  output reg         central_dma_active,
  output reg         serial_data_in,
  output reg         serial_bus_mode
);

  // registers
  reg [31:0] multifunction_terminal_routing_r;
  reg        ring_output_enable_r;
  reg        central_dma_enable_r;
  reg [4:0]  gp_output_r;
  reg [31:0] rdata_nxt;

  // three-stage pin synchronisers
  reg [6:0]  term_s1_r;
  reg [6:0]  term_s2_r;
  reg [6:0]  term_s3_r;
  reg [6:0]  term_level_r;
  reg [1:0]  strap_s1_r;
  reg [1:0]  strap_s2_r;
  reg [1:0]  strap_s3_r;
  reg [1:0]  strap_level_r;

  wire [3:0] multi_terminal_0_select;
  wire [3:0] multi_terminal_1_select;
  wire [3:0] multi_terminal_2_select;
  wire [3:0] multi_terminal_3_select;
  wire [3:0] multi_terminal_4_select;
  wire [3:0] multi_terminal_5_select;
  wire [3:0] multi_terminal_6_select;
  wire       serial_mode;
  wire       dma_path_ok;

  wire [16*`TERM_N-1:0] src_val;
  wire [16*`TERM_N-1:0] src_en;
  wire [`TERM_N-1:0]    force_sel;
  wire [`TERM_N-1:0]    force_val;
  wire [`TERM_N-1:0]    force_oe;
  wire [`SEL_W*`TERM_N-1:0] sel_all;

  // select field n of the routing word
  function [3:0] field_of;
    input [31:0] word;
    input [2:0]  idx;
    begin
      field_of = word[idx*`SEL_W +: `SEL_W];
    end
  endfunction

  // a level counts once the last two stages agree
  function agreed;
    input s2;
    input s3;
    input held;
    begin
      agreed = (s2 == s3) ? s3 : held;
    end
  endfunction

  assign multi_terminal_0_select =
    field_of(multifunction_terminal_routing_r, 3'd0);
  assign multi_terminal_1_select =
    field_of(multifunction_terminal_routing_r, 3'd1);
  assign multi_terminal_2_select =
    field_of(multifunction_terminal_routing_r, 3'd2);
  assign multi_terminal_3_select =
    field_of(multifunction_terminal_routing_r, 3'd3);
  assign multi_terminal_4_select =
    field_of(multifunction_terminal_routing_r, 3'd4);
  assign multi_terminal_5_select =
    field_of(multifunction_terminal_routing_r, 3'd5);
  assign multi_terminal_6_select =
    field_of(multifunction_terminal_routing_r, 3'd6);

  // all select fields side by side, terminal 0 at the right
  assign sel_all = {multi_terminal_6_select, multi_terminal_5_select,
    multi_terminal_4_select, multi_terminal_3_select,
    multi_terminal_2_select, multi_terminal_1_select,
    multi_terminal_0_select};

  // both strap pins pulled up select serial-bus mode
  assign serial_mode = strap_level_r[0] & strap_level_r[1];

  assign dma_path_ok = central_dma_enable_r &
    (multi_terminal_2_select == `CODE_DMA_FUNC) &
    (multi_terminal_5_select == `CODE_DMA_FUNC); // R15

  // terminal tables, code 15 at the left down to code 0
  assign src_val[0*16 +: 16] = {irq_lines[15], general_purpose_event,
    irq_lines[13], socket_activity_led, irq_lines[11:9], card_audio_pwm,
    video_port_select_0, video_port_status, irq_lines[5:3], pci_inta,
    gp_output_r[0], 1'b0}; // R13
  assign src_en[0*16 +: 16] = `T0_DRIVE_MASK; // R13

  assign src_val[1*16 +: 16] = {irq_lines[15], general_purpose_event,
    irq_lines[13], socket_activity_led, irq_lines[11:9], 1'b0,
    video_port_select_0, video_port_status, irq_lines[5:3], 1'b0,
    gp_output_r[1], 1'b0}; // R11
  assign src_en[1*16 +: 16] = `T1_DRIVE_MASK; // R16

  assign src_val[2*16 +: 16] = {irq_lines[7], general_purpose_event,
    1'b0, ring_indicate_output, irq_lines[11:9], card_audio_pwm,
    video_port_select_0, video_port_status, irq_lines[5:3],
    dma_request_out, gp_output_r[2], 1'b0}; // R10
  assign src_en[2*16 +: 16] = {2'b11, 1'b0, ring_output_enable_r,
    4'hF, 4'hF, 1'b1, dma_path_ok, 1'b1, 1'b0}; // R14

  assign src_val[3*16 +: 16] = {irq_lines[15:2], serialized_interrupt,
    1'b0}; // R09
  assign src_en[3*16 +: 16] = `T3_DRIVE_MASK &
    {14'h3FFF, serialized_interrupt_oe, 1'b0}; // R16

  assign src_val[4*16 +: 16] = {irq_lines[15], general_purpose_event,
    socket_activity_led, ring_indicate_output, 6'h00, irq_lines[5:4],
    4'h0}; // R07
  assign src_en[4*16 +: 16] = {3'b111, ring_output_enable_r, 6'h00,
    2'b11, 4'h0}; // R14

  assign src_val[5*16 +: 16] = {irq_lines[15], general_purpose_event,
    socket_activity_led, socket_activity_led, irq_lines[11:9],
    card_audio_pwm, video_port_select_0, video_port_status, 1'b0,
    irq_lines[4:3], 1'b0, gp_output_r[4], 1'b0}; // R06
  assign src_en[5*16 +: 16] = `T5_DRIVE_MASK; // R06

  assign src_val[6*16 +: 16] = {irq_lines[15:2], clkrun_out, 1'b0}; // R05
  assign src_en[6*16 +: 16] = `T6_DRIVE_MASK &
    {14'h3FFF, clkrun_oe, 1'b0}; // R16

  // serial-bus overrides: clock on terminal 4, open-drain data on 1
  assign force_sel = {2'b00, serial_mode, 2'b00, serial_mode, 1'b0};
  assign force_val = {2'b00, serial_clk_out, 4'h0}; // R08
  assign force_oe  = {2'b00, serial_clk_oe, 2'b00,
    serial_data_drive_low, 1'b0}; // R12

  genvar g;
  generate
    for (g = 0; g < `TERM_N; g = g + 1)
    begin : cells
      terminal_cell u_cell (
        .core_clk  (core_clk),
        .rst       (rst),
        .code      (sel_all[g*`SEL_W +: `SEL_W]),
        .src_val   (src_val[g*16 +: 16]),
        .src_en    (src_en[g*16 +: 16]),
        .force_sel (force_sel[g]),
        .force_val (force_val[g]),
        .force_oe  (force_oe[g]),
        .pin_out   (term_out[g]),
        .pin_oe    (term_oe[g])
      );
    end
  endgenerate

  // pin synchronisers; only the last two stages feed logic
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      term_s1_r     <= 7'h00;
      term_s2_r     <= 7'h00;
      term_s3_r     <= 7'h00;
      term_level_r  <= 7'h00;
      strap_s1_r    <= 2'h0;
      strap_s2_r    <= 2'h0;
      strap_s3_r    <= 2'h0;
      strap_level_r <= 2'h0;
    end
    else
    begin
      term_s1_r     <= term_in;
      term_s2_r     <= term_s1_r;
      term_s3_r     <= term_s2_r;
      strap_s1_r    <= {power_strap_b, power_strap_a};
      strap_s2_r    <= strap_s1_r;
      strap_s3_r    <= strap_s2_r;
      strap_level_r[0] <= agreed(strap_s2_r[0], strap_s3_r[0],
        strap_level_r[0]);
      strap_level_r[1] <= agreed(strap_s2_r[1], strap_s3_r[1],
        strap_level_r[1]);
      term_level_r  <= (term_s2_r & term_s3_r) |
        (~(term_s2_r ^ term_s3_r) & term_s3_r) |
        ((term_s2_r ^ term_s3_r) & term_level_r);
    end
  end

  // register file; routing may be rewritten at any time
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      multifunction_terminal_routing_r <= `ROUTING_RESET; // R01
      ring_output_enable_r <= 1'b0;
      central_dma_enable_r <= 1'b0;
      gp_output_r          <= `GP_OUTPUT_RESET;
    end
    else
    begin
      if (preload_valid)
        multifunction_terminal_routing_r <=
          preload_data & `ROUTING_WR_MASK; // R02
      else if (reg_wr && reg_addr == `OFS_ROUTING)
        multifunction_terminal_routing_r <=
          reg_wdata & `ROUTING_WR_MASK; // R04
      if (reg_wr && reg_addr == `OFS_ROUTER_CTRL)
      begin
        ring_output_enable_r <= reg_wdata[`CTRL_RING_EN_BIT];
        central_dma_enable_r <= reg_wdata[`CTRL_DMA_EN_BIT];
      end
      if (reg_wr && reg_addr == `OFS_GP_OUTPUT)
        gp_output_r <= reg_wdata[4:0] & `GP_OUTPUT_MASK;
    end
  end

  // read mux; unmapped addresses read zero
  always @*
  begin
    rdata_nxt = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_addr)
        `OFS_ROUTING:
          rdata_nxt = multifunction_terminal_routing_r; // R04
        `OFS_ROUTER_CTRL:
        begin
          rdata_nxt[`CTRL_RING_EN_BIT] = ring_output_enable_r;
          rdata_nxt[`CTRL_DMA_EN_BIT]  = central_dma_enable_r;
        end
        `OFS_GP_OUTPUT:
          rdata_nxt[4:0] = gp_output_r;
        `OFS_ROUTER_STATUS:
        begin
          rdata_nxt[`STAT_LEVELS_LSB +: 7] = term_level_r;
          rdata_nxt[`STAT_SERIAL_BIT]      = serial_mode;
          rdata_nxt[`STAT_DMA_BIT]         = dma_path_ok;
        end
        default:
          rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // registered outputs toward the core
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata          <= 32'h00000000;
      dma_grant_in       <= 1'b0;
      central_dma_active <= 1'b0;
      serial_data_in     <= 1'b1;
      serial_bus_mode    <= 1'b0;
    end
    else
    begin
      reg_rdata          <= rdata_nxt;
      dma_grant_in       <= dma_path_ok & term_level_r[5]; // R15
      central_dma_active <= dma_path_ok; // R15
      serial_data_in     <= serial_mode ? term_level_r[1] : 1'b1; // R12
      serial_bus_mode    <= serial_mode; // R08
    end
  end

endmodule

// ### mfunc_router_monitor.sv
// Purpose: port assertions for the terminal router
// Assumes: routing and ring enable shadowed from bus writes
// Notes:   bound to every router instance
`timescale 1ns/1ps
`include "mfunc_consts.vh"
module mfunc_router_monitor (
  input wire        core_clk,
  input wire        rst,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        preload_valid,
  input wire [31:0] preload_data,
  input wire [15:0] irq_lines,
  input wire        serialized_interrupt_oe,
  input wire        serial_clk_out,
  input wire        serial_clk_oe,
  input wire        serial_data_drive_low,
  input wire [6:0]  term_out,
  input wire [6:0]  term_oe,
  input wire        dma_grant_in,
  input wire        central_dma_active,
  input wire        serial_bus_mode
);
  reg  [27:0] sh_r;
  reg         ring_en_r;
  wire        irq6_sel = irq_lines[sh_r[27:24]];
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sh_r      <= 28'h0;
      ring_en_r <= 1'b0;
    end
    else
    begin
      if (preload_valid)
        sh_r <= preload_data[27:0];
      else if (reg_wr && reg_addr == `OFS_ROUTING)
        sh_r <= reg_wdata[27:0];
      if (reg_wr && reg_addr == `OFS_ROUTER_CTRL)
        ring_en_r <= reg_wdata[0];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence wr_rt;
    reg_wr && reg_addr == `OFS_ROUTING && !preload_valid;
  endsequence
  sequence rd_rt;
    reg_rd && reg_addr == `OFS_ROUTING && !preload_valid;
  endsequence
  AST_RST_IN: assert property ($fell(rst) |-> term_oe == 7'h00)
    else $error("terminal driven after reset");
  AST_WR_RD: assert property (wr_rt ##1 rd_rt |=>
    reg_rdata == {4'h0, $past(reg_wdata[27:0], 2)})
    else $error("routing readback wrong");
  AST_PRELOAD: assert property (preload_valid ##1 rd_rt |=>
    reg_rdata == {4'h0, $past(preload_data[27:0], 2)})
    else $error("preload not in routing");
  AST_T6_RSVD: assert property ($past(sh_r[27:24]) == 4'h0
    |-> !term_oe[6])
    else $error("reserved code drives terminal 6");
  AST_T6_IRQ: assert property ($past(sh_r[27:24]) > 4'h1
    |-> term_oe[6] && term_out[6] == $past(irq6_sel))
    else $error("terminal 6 interrupt route wrong");
  AST_T3_SER: assert property ($past(sh_r[15:12]) == 4'h1
    |-> term_oe[3] == $past(serialized_interrupt_oe))
    else $error("terminal 3 serial interrupt wrong");
  AST_RING: assert property ($past(sh_r[19:16]) == 4'hC
    && !$past(ring_en_r) && !serial_bus_mode
    && !$past(serial_bus_mode) |-> !term_oe[4])
    else $error("ring output leaked");
  AST_DMA: assert property (!central_dma_active
    && !$past(central_dma_active) && !$past(central_dma_active, 2)
    |-> !dma_grant_in)
    else $error("grant without dma path");
  AST_SER_T4: assert property (serial_bus_mode
    && $past(serial_bus_mode) |-> term_oe[4] == $past(serial_clk_oe)
    && term_out[4] == ($past(serial_clk_out) && $past(serial_clk_oe)))
    else $error("serial clock not on terminal 4");
  AST_SER_T1: assert property (serial_bus_mode
    && $past(serial_bus_mode) |-> !term_out[1]
    && term_oe[1] == $past(serial_data_drive_low))
    else $error("serial data not on terminal 1");
endmodule
bind mfunc_router mfunc_router_monitor mon_u (.core_clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .preload_valid, .preload_data,
  .irq_lines, .serialized_interrupt_oe, .serial_clk_out, .serial_clk_oe,
  .serial_data_drive_low, .term_out, .term_oe, .dma_grant_in,
  .central_dma_active, .serial_bus_mode);

// ### board_model.sv
// Purpose: board wiring seen by the multifunction terminals
// Assumes: undriven pins follow a changing board pattern
// Notes:   serial data line has a pull-up in serial mode
`timescale 1ns/1ps
module board_model (
  input  wire [6:0] term_out,
  input  wire [6:0] term_oe,
  input  wire [6:0] ext,
  input  wire       serial_sel,
  output wire [6:0] term_in,
  output wire       power_strap_a,
  output wire       power_strap_b
);
  wire [6:0] idle = serial_sel ? {ext[6:2], 1'b1, ext[0]} : ext;
  assign term_in = (term_oe & term_out) | (~term_oe & idle);
  assign power_strap_a = serial_sel;
  assign power_strap_b = serial_sel;
endmodule

// ### multifunction_terminal_router_tb.sv
// Purpose: self-checking bench for the terminal router
// Assumes: bus master as in the hand-over, board model on pins
// Notes:   read results pass through a queue of expected words
`timescale 1ns/1ps
`include "mfunc_consts.vh"
module multifunction_terminal_router_tb;
  logic        core_clk = 1'b0, rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, preload_data = 32'h0, q[$];
  logic        reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic        preload_valid = 1'b0, serial_sel = 1'b0;
  logic [30:0] fn = 31'h0;
  logic [6:0]  ext = 7'h00;
  logic [4:0]  gpo = 5'h00;
  integer      seed = 32'h815B, err_total = 0, samples_checked = 0;
  integer      cyc = 0, c, d;
  wire  [15:0] irq_lines;
  wire clkrun_out, clkrun_oe, serialized_interrupt, serialized_interrupt_oe,
    pci_inta, dma_request_out, video_port_status, video_port_select_0,
    card_audio_pwm, socket_activity_led, general_purpose_event,
    ring_indicate_output, serial_clk_out, serial_clk_oe,
    serial_data_drive_low, dma_grant_in, central_dma_active,
    serial_data_in, serial_bus_mode, power_strap_a, power_strap_b;
  wire  [31:0] reg_rdata;
  wire  [6:0]  term_in, term_out, term_oe;
  assign {irq_lines, clkrun_out, clkrun_oe, serialized_interrupt,
    serialized_interrupt_oe, pci_inta, dma_request_out, video_port_status,
    video_port_select_0, card_audio_pwm, socket_activity_led,
    general_purpose_event, ring_indicate_output, serial_clk_out,
    serial_clk_oe, serial_data_drive_low} = fn;
  mfunc_router dut_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .preload_valid, .preload_data, .irq_lines,
    .clkrun_out, .clkrun_oe, .serialized_interrupt, .serialized_interrupt_oe,
    .pci_inta, .dma_request_out, .video_port_status, .video_port_select_0,
    .card_audio_pwm, .socket_activity_led, .general_purpose_event,
    .ring_indicate_output, .serial_clk_out, .serial_clk_oe,
    .serial_data_drive_low, .power_strap_a, .power_strap_b, .term_in,
    .term_out, .term_oe, .dma_grant_in, .central_dma_active,
    .serial_data_in, .serial_bus_mode);
  board_model board_u (.term_out, .term_oe, .ext, .serial_sel, .term_in,
    .power_strap_a, .power_strap_b);
  always #20 core_clk = ~core_clk;
  task conclude;
  begin
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
      err_total = err_total + 1;
    end
  end
  endtask
  task bus(input w, input r, input [7:0] a, input [31:0] wd, input [31:0] e);
  begin
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= wd;
    if (r)
      q.push_back(e);
  end
  endtask
  task settle;
  begin
    bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  end
  endtask
  task rnd;
  begin
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    fn <= $random(seed);
    ext <= $random(seed);
  end
  endtask
  function [1:0] exp_pin(input t, input [3:0] k);
    case (k)
      4'h0: exp_pin = 2'b00;
      4'h1: exp_pin = {1'b1, gpo[t]};
      4'h2: exp_pin = t ? 2'b00 : {1'b1, pci_inta};
      4'h6: exp_pin = {1'b1, video_port_status};
      4'h7: exp_pin = {1'b1, video_port_select_0};
      4'h8: exp_pin = t ? 2'b00 : {1'b1, card_audio_pwm};
      4'hC: exp_pin = {1'b1, socket_activity_led};
      4'hE: exp_pin = {1'b1, general_purpose_event};
      default: exp_pin = {1'b1, irq_lines[k]};
    endcase
  endfunction
  always @(posedge core_clk)
  begin
    rd_d <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total = err_total + 1;
      conclude;
    end
  end
  always @(negedge core_clk)
    if (rd_d)
      chk(reg_rdata, q.pop_front());
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    settle;
    chk(term_oe, 7'h00);
    bus(1'b0, 1'b1, `OFS_ROUTING, 32'h0, 32'h0);
    bus(1'b0, 1'b1, 8'h44, 32'h0, 32'h0);
    bus(1'b1, 1'b0, `OFS_ROUTING, 32'hFFFFFFFF, 32'h0);
    bus(1'b0, 1'b1, `OFS_ROUTING, 32'h0, `ROUTING_WR_MASK);
    d = $random(seed);
    @(posedge core_clk);
    preload_valid <= 1'b1;
    preload_data <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= `OFS_ROUTING;
    reg_wdata <= ~d;
    bus(1'b0, 1'b1, `OFS_ROUTING, 32'h0, d & `ROUTING_WR_MASK);
    preload_valid <= 1'b0;
    gpo = $random(seed) & `GP_OUTPUT_MASK;
    bus(1'b1, 1'b0, `OFS_GP_OUTPUT, {27'h0, gpo}, 32'h0);
    // routing is rewritten freely since single programming is advisory
    for (c = 0; c < 16; c = c + 1)
    begin
      rnd;
      bus(1'b1, 1'b0, `OFS_ROUTING,
        {8'h0, c[3:0], c[3:0], 4'h0, c[3:0], c[3:0], c[3:0]}, 32'h0);
      settle;
      chk({term_oe[0], term_out[0]}, exp_pin(1'b0, c[3:0]));
      chk({term_oe[1], term_out[1]}, exp_pin(1'b1, c[3:0]));
      chk({term_oe[2], term_out[2]}, c == 2 || c == 12 || c == 13 ?
        2'b00 : c == 15 ? {1'b1, irq_lines[7]} : c == 1 ?
        {1'b1, gpo[2]} : exp_pin(1'b0, c[3:0]));
      chk({term_oe[4], term_out[4]}, c == 13 ?
        {1'b1, socket_activity_led} : c == 4 || c == 5 || c > 13 ?
        exp_pin(1'b0, c[3:0]) : 2'b00);
      chk({term_oe[5], term_out[5]}, c == 2 || c == 5 ? 2'b00 :
        c == 13 ? {1'b1, socket_activity_led} : c == 1 ?
        {1'b1, gpo[4]} : exp_pin(1'b0, c[3:0]));
      rnd;
      bus(1'b1, 1'b0, `OFS_ROUTING, {4'h0, c[3:0], 8'h0, c[3:0], 12'h0}, 0);
      settle;
      chk({term_oe[6], term_out[6]}, c == 0 ? 2'b00 : c == 1 ?
        {clkrun_oe, clkrun_out & clkrun_oe} : {1'b1, irq_lines[c]});
      chk({term_oe[3], term_out[3]}, c == 0 ? 2'b00 : c == 1 ?
        {serialized_interrupt_oe,
         serialized_interrupt & serialized_interrupt_oe} :
        {1'b1, irq_lines[c]});
    end
    rnd;
    bus(1'b1, 1'b0, `OFS_ROUTING, 32'h000C0C00, 32'h0);
    bus(1'b1, 1'b0, `OFS_ROUTER_CTRL, 32'h0, 32'h0);
    settle;
    chk({term_oe[4], term_oe[2]}, 2'b00);
    bus(1'b1, 1'b0, `OFS_ROUTER_CTRL, 32'h1, 32'h0);
    settle;
    chk({term_oe[4], term_out[4], term_oe[2], term_out[2]},
      {2{1'b1, ring_indicate_output}});
    bus(1'b1, 1'b0, `OFS_ROUTER_CTRL, 32'h2, 32'h0);
    bus(1'b1, 1'b0, `OFS_ROUTING, 32'h00200200, 32'h0);
    ext <= 7'h7F;
    settle;
    settle;
    chk({central_dma_active, dma_grant_in, term_oe[2], term_out[2],
      term_oe[5]}, {3'b111, dma_request_out, 1'b0});
    bus(1'b0, 1'b1, `OFS_ROUTER_CTRL, 32'h0, 32'h2);
    bus(1'b0, 1'b1, `OFS_ROUTER_STATUS, 32'h0, {22'h0, 2'b10, 1'b0,
      4'hF, dma_request_out, 2'b11});
    bus(1'b0, 1'b1, `OFS_GP_OUTPUT, 32'h0, {27'h0, gpo});
    bus(1'b1, 1'b0, `OFS_ROUTER_CTRL, 32'h0, 32'h0);
    settle;
    chk({central_dma_active, dma_grant_in}, 2'b00);
    bus(1'b1, 1'b0, `OFS_ROUTING, 32'h0, 32'h0);
    serial_sel <= 1'b1;
    fn[0] <= 1'b1;
    settle;
    settle;
    chk({serial_bus_mode, term_oe[4], term_out[4], term_oe[1],
      term_out[1], serial_data_in},
      {1'b1, serial_clk_oe, serial_clk_out & serial_clk_oe, 3'b100});
    @(posedge core_clk);
    fn[0] <= 1'b0;
    settle;
    settle;
    chk({term_oe[1], serial_data_in}, 2'b01);
    conclude;
  end
endmodule
